// >>> verilog/frequency_threshold_trigger.sv
// module: frequency threshold trigger with axi4-lite register slave
// Function
// - count only rising edges of the pulse input
// - dedicated fast input counts correctly up to five kilohertz
// - gate interval 0.05 s to 99.99 s in hundredths
// - gate interval may come from another block's actual value
// - pulses accumulated over each gate interval form the measured value
// - on>=off: high above on, low at or below off
// - on<off: high while on<=count<off
// - compare once per gate interval only
// - gate timebase is hundredths of a second only with the default TICK_CYCLES
// - one second gate gives count equal to hertz
// - measured value is total pulses in one full interval; the code saturates it at CNT_SAT (9999)
`timescale 1ns/1ps
module frequency_threshold_trigger #(
    parameter int unsigned TICK_CYCLES = freq_trig_pkg::TICK_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        pulse_in,
    input  wire logic [15:0] ext_gate_value,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             trig_out,
    output logic             gate_done
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [13:0] clamp_thr(input logic [13:0] v);
        clamp_thr = (v > freq_trig_pkg::THRESH_MAX) ? freq_trig_pkg::THRESH_MAX : v;
    endfunction

    // out-of-range referenced values round to the nearest valid gate
    function automatic logic [13:0] clamp_gate(input logic [15:0] v);
        if (v < {2'b00, freq_trig_pkg::GATE_MIN}) begin
            clamp_gate = freq_trig_pkg::GATE_MIN;
        end else if (v > {2'b00, freq_trig_pkg::GATE_MAX}) begin
            clamp_gate = freq_trig_pkg::GATE_MAX;
        end else begin
            clamp_gate = v[13:0];
        end
    endfunction

    function automatic logic [13:0] wr_field(input logic [31:0] d, input logic [3:0] s,
                                             input logic [13:0] old);
        logic [13:0] r;
        r = old;
        if (s[0]) begin
            r[7:0] = d[7:0];
        end
        if (s[1]) begin
            r[13:8] = d[13:8];
        end
        wr_field = r;
    endfunction

    // ****************************************************************
    // pulse input synchroniser and edge detect
    // ****************************************************************
    logic [2:0] sync_q, sync_d;
    logic       level_q, level_d;
    logic       rise;

    always_comb begin
        sync_d  = {sync_q[1:0], pulse_in};
        level_d = level_q;
        rise    = 1'b0;
        if (sync_q[1] == sync_q[2]) begin
            level_d = sync_q[2];
            rise    = sync_q[2] & ~level_q;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_q  <= 3'b000;
            level_q <= 1'b0;
        end else if (clk_en) begin
            sync_q  <= sync_d;
            level_q <= level_d;
        end
    end

    // ****************************************************************
    // register file
    // ****************************************************************
    freq_trig_pkg::cfg_type cfg_q, cfg_d;
    logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [7:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic        awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic [13:0] total_q;
    logic        out_q;

    always_comb begin
        cfg_d     = cfg_q;
        aw_hold_d = aw_hold_q;
        w_hold_d  = w_hold_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        if (s_axi_awvalid && !aw_hold_q && !bvalid_q) begin
            aw_hold_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_hold_q && !bvalid_q) begin
            w_hold_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (aw_hold_q && w_hold_q) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = freq_trig_pkg::RESP_OKAY;
            unique case (awaddr_q)
                freq_trig_pkg::ADDR_ON:
                    cfg_d.on_thr = clamp_thr(wr_field(wdata_q, wstrb_q, cfg_q.on_thr));
                freq_trig_pkg::ADDR_OFF:
                    cfg_d.off_thr = clamp_thr(wr_field(wdata_q, wstrb_q, cfg_q.off_thr));
                freq_trig_pkg::ADDR_GATE:
                    cfg_d.gate = clamp_gate({2'b00, wr_field(wdata_q, wstrb_q, cfg_q.gate)});
                freq_trig_pkg::ADDR_CTRL: begin
                    if (wstrb_q[0]) begin
                        cfg_d.gate_ext = wdata_q[freq_trig_pkg::CTRL_EXT_BIT];
                    end
                end
                freq_trig_pkg::ADDR_TOTAL, freq_trig_pkg::ADDR_STAT: begin
                end
                default:
                    bresp_d = freq_trig_pkg::RESP_SLVERR;
            endcase
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d  = freq_trig_pkg::RESP_OKAY;
            rdata_d  = 32'h0000_0000;
            unique case (s_axi_araddr)
                freq_trig_pkg::ADDR_ON:    rdata_d[13:0] = cfg_q.on_thr;
                freq_trig_pkg::ADDR_OFF:   rdata_d[13:0] = cfg_q.off_thr;
                freq_trig_pkg::ADDR_GATE:  rdata_d[13:0] = cfg_q.gate;
                freq_trig_pkg::ADDR_CTRL:  rdata_d[freq_trig_pkg::CTRL_EXT_BIT] = cfg_q.gate_ext;
                freq_trig_pkg::ADDR_TOTAL: rdata_d[13:0] = total_q;
                freq_trig_pkg::ADDR_STAT:  rdata_d[freq_trig_pkg::STAT_OUT_BIT] = out_q;
                default:                   rresp_d = freq_trig_pkg::RESP_SLVERR;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        // readies are registered so every bus output leaves a flop
        awready_d = ~aw_hold_d & ~bvalid_d;
        wready_d  = ~w_hold_d & ~bvalid_d;
        arready_d = ~rvalid_d;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_q     <= '{on_thr: 14'h0000, off_thr: 14'h0000,
                           gate: freq_trig_pkg::GATE_RST, gate_ext: 1'b0};
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'b00;
            rvalid_q  <= 1'b0;
            rresp_q   <= 2'b00;
            rdata_q   <= 32'h0000_0000;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            arready_q <= 1'b1;
        end else if (clk_en) begin
            cfg_q     <= cfg_d;
            aw_hold_q <= aw_hold_d;
            w_hold_q  <= w_hold_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            arready_q <= arready_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // ****************************************************************
    // gate timebase, counting and evaluation
    // ****************************************************************
    logic [freq_trig_pkg::TICK_W-1:0] tick_q, tick_d;
    logic [13:0] hund_q, hund_d;
    logic [13:0] acc_q, acc_d;
    logic [13:0] total_d;
    logic        out_d, done_q, done_d;
    logic [13:0] gate_sel;
    logic        tick, boundary;

    always_comb begin
        // gate counts ticks of TICK_CYCLES clocks, hundredths of a second only with the default TICK_CYCLES
        gate_sel = cfg_q.gate_ext ? clamp_gate(ext_gate_value) : cfg_q.gate;
        tick     = (tick_q == freq_trig_pkg::TICK_W'(TICK_CYCLES - 1));
        tick_d   = tick ? '0 : tick_q + 1'b1;
        hund_d   = hund_q;
        boundary = 1'b0;
        if (tick) begin
            if (hund_q + 14'h0001 >= gate_sel) begin
                hund_d   = 14'h0000;
                boundary = 1'b1;
            end else begin
                hund_d = hund_q + 14'h0001;
            end
        end
        acc_d   = acc_q;
        total_d = total_q;
        out_d   = out_q;
        done_d  = 1'b0;
        if (boundary) begin
            // a rising edge on the boundary cycle belongs to the next interval
            acc_d   = {13'h0000, rise};
            total_d = acc_q;
            done_d  = 1'b1;
            if (cfg_q.on_thr >= cfg_q.off_thr) begin
                if (acc_q > cfg_q.on_thr) begin
                    out_d = 1'b1;
                end else if (acc_q <= cfg_q.off_thr) begin
                    out_d = 1'b0;
                end else begin
                    out_d = out_q;
                end
            end else begin
                out_d = (acc_q >= cfg_q.on_thr) && (acc_q < cfg_q.off_thr);
            end
        end else if (rise && acc_q != freq_trig_pkg::CNT_SAT) begin
            acc_d = acc_q + 14'h0001;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_q  <= '0;
            hund_q  <= 14'h0000;
            acc_q   <= 14'h0000;
            total_q <= 14'h0000;
            out_q   <= 1'b0;
            done_q  <= 1'b0;
        end else if (clk_en) begin
            tick_q  <= tick_d;
            hund_q  <= hund_d;
            acc_q   <= acc_d;
            total_q <= total_d;
            out_q   <= out_d;
            done_q  <= done_d;
        end
    end

    assign trig_out  = out_q;
    assign gate_done = done_q;

endmodule

// >>> pkg/freq_trig_pkg.sv
// package: constants and carrier types of the frequency threshold trigger
package freq_trig_pkg;

    // ****************************************************************
    // clock and timebase
    // ****************************************************************
    localparam int unsigned CLK_HZ           = 25000000;
    localparam int unsigned HUNDREDTH_PER_S  = 100;
    localparam int unsigned TICK_CYCLES      = CLK_HZ / HUNDREDTH_PER_S;
    localparam int          TICK_W           = 18;

    // ****************************************************************
    // setting ranges
    // ****************************************************************
    localparam logic [13:0] THRESH_MAX       = 14'h270f;
    localparam logic [13:0] GATE_MIN         = 14'h0005;
    localparam logic [13:0] GATE_MAX         = 14'h270f;
    localparam logic [13:0] GATE_RST         = 14'h0064;
    localparam int          CNT_W            = 14;
    localparam logic [13:0] CNT_SAT          = 14'h270f;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0]  ADDR_ON          = 8'h00;
    localparam logic [7:0]  ADDR_OFF         = 8'h04;
    localparam logic [7:0]  ADDR_GATE        = 8'h08;
    localparam logic [7:0]  ADDR_CTRL        = 8'h0c;
    localparam logic [7:0]  ADDR_TOTAL       = 8'h10;
    localparam logic [7:0]  ADDR_STAT        = 8'h14;
    localparam int          CTRL_EXT_BIT     = 0;
    localparam int          STAT_OUT_BIT     = 0;
    localparam logic [1:0]  RESP_OKAY        = 2'b00;
    localparam logic [1:0]  RESP_SLVERR      = 2'b10;

    typedef struct packed {
        logic [13:0] on_thr;
        logic [13:0] off_thr;
        logic [13:0] gate;
        logic        gate_ext;
    } cfg_type;

endpackage

// >>> verif/freq_trig_props.sv
// checker: port-level properties of the frequency threshold trigger
`timescale 1ns/1ps
module freq_trig_props (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        clk_en,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        trig_out,
    input wire logic        gate_done
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_out_at_gate: assert property ($changed(trig_out) |-> gate_done)
        else $error("trigger output moved away from a gate boundary");
    a_done_single: assert property (gate_done && clk_en |=> !gate_done)
        else $error("gate boundary pulse longer than one cycle");
    a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    a_freeze_hold: assert property (!clk_en |=> $stable(trig_out) && $stable(gate_done))
        else $error("outputs moved while clock enable low");
endmodule

bind frequency_threshold_trigger freq_trig_props chk_i (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .clk_en        (clk_en),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .trig_out      (trig_out),
    .gate_done     (gate_done)
);

// >>> verif/pulse_source.sv
// model: external pulse source feeding the counting input
`timescale 1ns/1ps
module pulse_source (
    input wire logic ref_clk,
    output logic     pulse_out
);
    initial pulse_out = 1'h0;

    // rising edges only carry the count; hp sets the level length in cycles
    task automatic fire(input int n, input int hp);
        repeat (n) begin
            repeat (hp) @(posedge ref_clk);
            pulse_out <= 1'h1;
            repeat (hp) @(posedge ref_clk);
            pulse_out <= 1'h0;
        end
    endtask
endmodule

// >>> verif/frequency_threshold_trigger_bench.sv
// testbench: register access and threshold evaluation of the trigger
`timescale 1ns/1ps
module frequency_threshold_trigger_bench;
    logic        ref_clk = 1'h0;
    logic        rst = 1'h1;
    logic        clk_en = 1'h1;
    logic        pulse_in;
    logic [15:0] ext_gate_value = 16'h0005;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        trig_out, gate_done;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] rst_val [6] = '{32'h0, 32'h0, 32'h64, 32'h0, 32'h0, 32'h0};
    logic [31:0] n_tab [6] = '{32'ha, 32'h7, 32'h5, 32'h9, 32'h3, 32'h6};
    logic [31:0] on_tab [6] = '{32'h9, 32'h9, 32'h9, 32'h9, 32'h3, 32'h3};
    logic [31:0] off_tab [6] = '{32'h5, 32'h5, 32'h5, 32'h5, 32'h6, 32'h6};
    logic        exp_tab [6] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0};
    int          err_count = 0;
    int          checks_done = 0;
    int          k;

    always #20 ref_clk = ~ref_clk;

    // shortened timebase: one hundredth lasts 200 cycles, shortest gate 1000 cycles
    frequency_threshold_trigger #(
        .TICK_CYCLES    (32'h0000_00c8)
    ) dut (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .clk_en         (clk_en),
        .pulse_in       (pulse_in),
        .ext_gate_value (ext_gate_value),
        .s_axi_awaddr   (s_axi_awaddr),
        .s_axi_awvalid  (s_axi_awvalid),
        .s_axi_awready  (s_axi_awready),
        .s_axi_wdata    (s_axi_wdata),
        .s_axi_wstrb    (s_axi_wstrb),
        .s_axi_wvalid   (s_axi_wvalid),
        .s_axi_wready   (s_axi_wready),
        .s_axi_bresp    (s_axi_bresp),
        .s_axi_bvalid   (s_axi_bvalid),
        .s_axi_bready   (s_axi_bready),
        .s_axi_araddr   (s_axi_araddr),
        .s_axi_arvalid  (s_axi_arvalid),
        .s_axi_arready  (s_axi_arready),
        .s_axi_rdata    (s_axi_rdata),
        .s_axi_rresp    (s_axi_rresp),
        .s_axi_rvalid   (s_axi_rvalid),
        .s_axi_rready   (s_axi_rready),
        .trig_out       (trig_out),
        .gate_done      (gate_done)
    );
    pulse_source src (.ref_clk(ref_clk), .pulse_out(pulse_in));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        if (i == 50) begin
            err_count++;
            final_report();
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        int i;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        if (i == 50) begin
            err_count++;
            final_report();
        end
        chk(rd, exp);
    endtask

    // bound covers one shortest gate of 1000 cycles plus slack
    task automatic wait_gate;
        int i;
        for (i = 0; i < 1300; i++) begin
            @(posedge ref_clk);
            if (gate_done === 1'h1) break;
        end
        if (i == 1300) begin
            err_count++;
            final_report();
        end
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'h0;
        for (k = 0; k < 6; k++) rdc(8'(k * 4), rst_val[k]);
        $display("test reset values done");
        wr(freq_trig_pkg::ADDR_ON, 32'hffff);
        rdc(freq_trig_pkg::ADDR_ON, 32'h270f);
        wr(freq_trig_pkg::ADDR_GATE, 32'h1);
        rdc(freq_trig_pkg::ADDR_GATE, 32'h5);
        wr(freq_trig_pkg::ADDR_GATE, 32'h2710);
        rdc(freq_trig_pkg::ADDR_GATE, 32'h270f);
        wr(8'h20, 32'h1);
        chk(32'(resp), 32'(freq_trig_pkg::RESP_SLVERR));
        wr(freq_trig_pkg::ADDR_TOTAL, 32'h7);
        chk(32'(resp), 32'(freq_trig_pkg::RESP_OKAY));
        rdc(freq_trig_pkg::ADDR_TOTAL, 32'h0);
        chk(32'(resp), 32'(freq_trig_pkg::RESP_OKAY));
        rdc(8'h20, 32'h0);
        chk(32'(resp), 32'(freq_trig_pkg::RESP_SLVERR));
        $display("test limits and access done");
        wr(freq_trig_pkg::ADDR_CTRL, 32'h1);
        rdc(freq_trig_pkg::ADDR_CTRL, 32'h1);
        wait_gate();
        $display("test external gate done");
        for (k = 0; k < 6; k++) begin
            wr(freq_trig_pkg::ADDR_ON, on_tab[k]);
            wr(freq_trig_pkg::ADDR_OFF, off_tab[k]);
            src.fire(int'(n_tab[k]), k[0] ? 6 : 2);
            if (k == 0) begin
                clk_en <= 1'h0;
                repeat (5) @(posedge ref_clk);
                clk_en <= 1'h1;
            end
            wait_gate();
            chk(32'(trig_out), 32'(exp_tab[k]));
            rdc(freq_trig_pkg::ADDR_TOTAL, n_tab[k]);
            rdc(freq_trig_pkg::ADDR_STAT, 32'(exp_tab[k]));
        end
        $display("test threshold evaluation done");
        final_report();
    end
endmodule
